//--- tec_timer.sv
// Purpose: Eight-bit timer/event counter channel with AXI4-Lite registers
// Assumes: aclk is the peripheral clock; synchronous active-low reset
// Notes:   Byte lane 0 carries every field
//          Stop the timer before changing the clock select
// Function
// - Counter is 8-bit, read-only to software
// - Counter increments on each count clock tick
// - Reset or run-bit clear zeroes counter
// - Clear mode: counter restarts at zero on match
// - Non-PWM: match raises the match interrupt
// - PWM: match drives output inactive, no interrupt
// - Compare register read/write, any 8-bit value
// - Compare register resets to zero
// - Clock select resets zero, bits 7..3 zero
// - Select 000 falling, 001 rising event edge
// - Select 010..111 picks divided peripheral clock
// - Counter held at zero until run bit set
// - Mode bit: 0 clear-on-match, 1 PWM
// - Output enable 0 forces pin low
// - Set/clear bits: 01 clear, 10 set, 00 hold
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module tec_timer
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [17:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [17:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        event_in_pin,
    output logic             timer_out_pin,
    output logic             irq
);
    // Software-visible state
    logic [2:0]              clock_select_q;
    logic                    count_run_bit_q;
    logic                    pwm_mode_select_q;
    logic                    invert_or_polarity_bit_q;
    logic                    output_enable_bit_q;
    logic [7:0]              compare_value_q;
    logic [7:0]              channel_counter_q;
    logic [tec_pkg::IRQ_W-1:0] irq_status_q;
    logic [tec_pkg::IRQ_W-1:0] irq_mask_q;
    logic                    out_ff_q;

    // Bus state
    logic [17:0]             awaddr_q;
    logic                    aw_held_q;
    logic [31:0]             wdata_q;
    logic [3:0]              wstrb_q;
    logic                    w_held_q;
    logic                    bvalid_q;
    logic [1:0]              bresp_q;
    logic                    rvalid_q;
    logic [31:0]             rdata_q;
    logic [1:0]              rresp_q;

    // Derived strobes
    logic                    wr_fire;
    logic                    rd_fire;
    logic                    tick;
    logic                    match;
    logic                    match_tick;
    logic                    wrap_tick;
    logic [7:0]              wbyte;
    logic [tec_pkg::IRQ_W-1:0] irq_events;

    // Write selects and read-back image
    logic                    wr_lane0;
    logic                    wr_clk_sel;
    logic                    wr_mode_ctl;
    logic                    wr_compare;
    logic                    wr_status;
    logic                    wr_mask;
    logic                    ff_write;
    logic                    pwm_run;
    logic                    match_irq;
    logic [7:0]              mode_rd;

    tec_tick_if tk ();

    // Returns 1 when the address decodes to a mapped register
    function automatic logic is_mapped(input logic [17:0] a);
        is_mapped = (a == tec_pkg::ADDR_CLK_SEL)    || (a == tec_pkg::ADDR_MODE_CTL)
                 || (a == tec_pkg::ADDR_COUNT)      || (a == tec_pkg::ADDR_COMPARE)
                 || (a == tec_pkg::ADDR_IRQ_STATUS) || (a == tec_pkg::ADDR_IRQ_MASK);
    endfunction

    tec_count_enable u_cen
    (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .event_in_pin (event_in_pin),
        .tk           (tk.gen)
    );

    assign tk.sel = clock_select_q;
    assign tk.run = count_run_bit_q;
    assign tick   = tk.tick;

    // Write address and data may arrive in either order
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
    assign wbyte         = wdata_q[7:0];

    // Write selects, decoded once so every register sees the same strobe
    assign wr_lane0    = wr_fire && wstrb_q[0];
    assign wr_clk_sel  = wr_lane0 && (awaddr_q == tec_pkg::ADDR_CLK_SEL);
    assign wr_mode_ctl = wr_lane0 && (awaddr_q == tec_pkg::ADDR_MODE_CTL);
    assign wr_compare  = wr_lane0 && (awaddr_q == tec_pkg::ADDR_COMPARE);
    assign wr_status   = wr_lane0 && (awaddr_q == tec_pkg::ADDR_IRQ_STATUS);
    assign wr_mask     = wr_lane0 && (awaddr_q == tec_pkg::ADDR_IRQ_MASK);
    // Set and clear together (11) is refused and leaves the flip-flop alone
    assign ff_write    = wr_mode_ctl && (wbyte[tec_pkg::MC_SET] ^ wbyte[tec_pkg::MC_CLR]);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_held_q <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held_q <= 1'b0;
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= tec_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= is_mapped(awaddr_q) ? tec_pkg::RESP_OKAY : tec_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // Clock select register; only low byte lane matters
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            clock_select_q <= tec_pkg::RST_CLK_SEL;
        else if (wr_clk_sel)
            clock_select_q <= wbyte[2:0];
    end

    // Mode control register; set/clear bits are write-only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_run_bit_q          <= 1'b0;
            pwm_mode_select_q        <= 1'b0;
            invert_or_polarity_bit_q <= 1'b0;
            output_enable_bit_q      <= 1'b0;
        end
        else if (wr_mode_ctl)
        begin
            count_run_bit_q          <= wbyte[tec_pkg::MC_RUN];
            pwm_mode_select_q        <= wbyte[tec_pkg::MC_PWM];
            invert_or_polarity_bit_q <= wbyte[tec_pkg::MC_POL];
            output_enable_bit_q      <= wbyte[tec_pkg::MC_OE];
        end
    end

    // Compare register; software keeps it steady while clear mode runs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            compare_value_q <= tec_pkg::RST_BYTE;
        else if (wr_compare)
            compare_value_q <= wbyte;
    end

    // Match is tested against the value the counter holds now
    assign match      = (channel_counter_q == compare_value_q);
    assign match_tick = tick && match;
    assign wrap_tick  = tick && (channel_counter_q == '1) && !match;

    // PWM shapes the pin only while counting; its match never interrupts
    assign pwm_run    = count_run_bit_q && pwm_mode_select_q;
    assign match_irq  = match_tick && !pwm_mode_select_q;

    // Counter: writes from software have no path here
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !count_run_bit_q)
            channel_counter_q <= tec_pkg::RST_BYTE;
        else if (tick)
        begin
            if (!pwm_mode_select_q && match)
                channel_counter_q <= tec_pkg::RST_BYTE;
            else
                channel_counter_q <= channel_counter_q + 8'h01;
        end
    end

    // Output flip-flop: software set/clear, toggle on match, PWM pattern
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            out_ff_q <= 1'b0;
        else if (ff_write)
            out_ff_q <= wbyte[tec_pkg::MC_SET];
        else if (pwm_run)
        begin
            // Active from counter wrap until match, then inactive
            if (match_tick)
                out_ff_q <= 1'b0;
            else if (wrap_tick)
                out_ff_q <= 1'b1;
        end
        else if (match_tick && invert_or_polarity_bit_q)
            out_ff_q <= ~out_ff_q;
    end

    // Pin: forced low while disabled; PWM polarity applied at the pin
    always_comb
    begin
        if (!output_enable_bit_q)
            timer_out_pin = 1'b0;
        else if (pwm_mode_select_q)
            timer_out_pin = out_ff_q ^ invert_or_polarity_bit_q;
        else
            timer_out_pin = out_ff_q;
    end

    // Event sources: match outside PWM, and counter overflow
    always_comb
    begin
        irq_events                     = '0;
        irq_events[tec_pkg::IRQ_MATCH] = match_irq;
        irq_events[tec_pkg::IRQ_OVF]   = wrap_tick;
    end

    // Sticky status, write-one-to-clear; a new event beats the clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_status_q <= '0;
        else if (wr_status)
            irq_status_q <= (irq_status_q & ~wbyte[tec_pkg::IRQ_W-1:0]) | irq_events;
        else
            irq_status_q <= irq_status_q | irq_events;
    end

    // Mask register gates status onto the line
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_mask_q <= '0;
        else if (wr_mask)
            irq_mask_q <= wbyte[tec_pkg::IRQ_W-1:0];
    end
    assign irq = |(irq_status_q & irq_mask_q);

    // Mode register as read back; set and clear bits are write-only
    always_comb
    begin
        mode_rd                  = '0;
        mode_rd[tec_pkg::MC_RUN] = count_run_bit_q;
        mode_rd[tec_pkg::MC_PWM] = pwm_mode_select_q;
        mode_rd[tec_pkg::MC_POL] = invert_or_polarity_bit_q;
        mode_rd[tec_pkg::MC_OE]  = output_enable_bit_q;
    end

    // Read channel; one read in flight, answered one cycle after address
    assign s_axi_arready = !rvalid_q;
    assign rd_fire       = s_axi_arvalid && !rvalid_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= tec_pkg::RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_q <= 1'b1;
            rresp_q  <= is_mapped(s_axi_araddr) ? tec_pkg::RESP_OKAY : tec_pkg::RESP_SLVERR;
            rdata_q  <= '0;
            unique case (s_axi_araddr)
                tec_pkg::ADDR_CLK_SEL:    rdata_q[2:0] <= clock_select_q;
                tec_pkg::ADDR_MODE_CTL:   rdata_q[7:0] <= mode_rd;
                tec_pkg::ADDR_COUNT:      rdata_q[7:0] <= channel_counter_q;
                tec_pkg::ADDR_COMPARE:    rdata_q[7:0] <= compare_value_q;
                tec_pkg::ADDR_IRQ_STATUS: rdata_q[tec_pkg::IRQ_W-1:0] <= irq_status_q;
                tec_pkg::ADDR_IRQ_MASK:   rdata_q[tec_pkg::IRQ_W-1:0] <= irq_mask_q;
                default:                  rdata_q <= '0;
            endcase
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

endmodule // tec_timer

//--- tec_pkg.sv
// Purpose: Shared constants and types for the eight-bit timer/event counter
// Assumes: One clock (aclk); registers reached over AXI4-Lite, one word each
// Notes:   Byte offsets are word aligned; narrow fields sit in the low bits
package tec_pkg;

    // Byte addresses; the clock select offset is a word index, so times four
    localparam int          ADDR_W           = 18;
    localparam logic [15:0] IDX_CLK_SEL      = 16'hff6a;
    localparam logic [17:0] ADDR_CLK_SEL     = {IDX_CLK_SEL, 2'h0};
    localparam logic [17:0] ADDR_MODE_CTL    = 18'h3fdac;
    localparam logic [17:0] ADDR_COUNT       = 18'h3fdb0;
    localparam logic [17:0] ADDR_COMPARE     = 18'h3fdb4;
    localparam logic [17:0] ADDR_IRQ_STATUS  = 18'h3fdb8;
    localparam logic [17:0] ADDR_IRQ_MASK    = 18'h3fdbc;

    // Reset values
    localparam logic [7:0]  RST_BYTE         = 8'h00;
    localparam logic [2:0]  RST_CLK_SEL      = 3'h0;

    // Mode control field positions
    localparam int          MC_RUN           = 7;
    localparam int          MC_PWM           = 6;
    localparam int          MC_SET           = 3;
    localparam int          MC_CLR           = 2;
    localparam int          MC_POL           = 1;
    localparam int          MC_OE            = 0;
    localparam logic [7:0]  MC_RD_MASK       = 8'hc3;

    // Interrupt status bit positions
    localparam int          IRQ_MATCH        = 0;
    localparam int          IRQ_OVF          = 1;
    localparam int          IRQ_W            = 2;

    // Clock-select codes
    typedef enum logic [2:0]
    {
        CS_EV_FALL = 3'h0,
        CS_EV_RISE = 3'h1,
        CS_DIV1    = 3'h2,
        CS_DIV2    = 3'h3,
        CS_DIV4    = 3'h4,
        CS_DIV64   = 3'h5,
        CS_DIV256  = 3'h6,
        CS_DIV8192 = 3'h7
    } tec_clk_sel_type;

    // Prescaler taps (divide by 2^tap)
    localparam int          PRE_W            = 13;
    localparam int          TAP_DIV2         = 1;
    localparam int          TAP_DIV4         = 2;
    localparam int          TAP_DIV64        = 6;
    localparam int          TAP_DIV256       = 8;
    localparam int          TAP_DIV8192      = 13;

    // AXI response codes
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage

//--- tec_tick_if.sv
// Purpose: Carries the count-enable tick between prescaler and counter
// Assumes: Same clock domain on both sides
// Notes:   Tick is a one-cycle pulse
`timescale 1ns/1ns
interface tec_tick_if;
    logic [2:0] sel;
    logic       run;
    logic       tick;
    modport ctl (output sel, output run, input tick);
    modport gen (input sel, input run, output tick);
endinterface // tec_tick_if

//--- tec_count_enable.sv
// Purpose: Builds the one-cycle count enable from prescaler or event pin
// Assumes: event_in_pin is asynchronous to aclk
// Notes:   Prescaler is held clear while stopped, so first tick is a full period
`timescale 1ns/1ns
module tec_count_enable
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic event_in_pin,
    tec_tick_if.gen   tk
);
    logic [tec_pkg::PRE_W-1:0] pre_q;
    logic [tec_pkg::PRE_W:0]   pre_nx;
    logic                      sync1_q;
    logic                      sync2_q;
    logic                      prev_q;
    logic [tec_pkg::PRE_W:0]   carry;

    // Two-stage synchroniser for the event pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end
        else
        begin
            sync1_q <= event_in_pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Free prescaler, cleared while stopped
    assign pre_nx = {1'b0, pre_q} + {{tec_pkg::PRE_W{1'b0}}, 1'b1};
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !tk.run)
            pre_q <= '0;
        else
            pre_q <= pre_nx[tec_pkg::PRE_W-1:0];
    end

    // Carry out of bit k-1 marks a divide-by-2^k period
    genvar k;
    generate
        for (k = 0; k <= tec_pkg::PRE_W; k++)
        begin : g_carry
            if (k == 0)
                assign carry[k] = 1'b1;
            else
                assign carry[k] = &pre_q[k-1:0];
        end
    endgenerate

    // Selected edge or divided clock becomes the tick
    always_comb
    begin
        unique case (tec_pkg::tec_clk_sel_type'(tk.sel))
            tec_pkg::CS_EV_FALL: tk.tick = prev_q & ~sync2_q;
            tec_pkg::CS_EV_RISE: tk.tick = ~prev_q & sync2_q;
            tec_pkg::CS_DIV1:    tk.tick = 1'b1;
            tec_pkg::CS_DIV2:    tk.tick = carry[tec_pkg::TAP_DIV2];
            tec_pkg::CS_DIV4:    tk.tick = carry[tec_pkg::TAP_DIV4];
            tec_pkg::CS_DIV64:   tk.tick = carry[tec_pkg::TAP_DIV64];
            tec_pkg::CS_DIV256:  tk.tick = carry[tec_pkg::TAP_DIV256];
            tec_pkg::CS_DIV8192: tk.tick = carry[tec_pkg::TAP_DIV8192];
        endcase
        if (!tk.run)
            tk.tick = 1'b0;
    end
endmodule // tec_count_enable

//--- tec_timer_chk.sv
// Purpose: Port-level assertions for the timer channel and its register bus
// Assumes: One clock; synchronous active-low reset
// Notes:   Sees only top-level ports, so counting itself is judged by the bench
`timescale 1ns/1ns
module tec_timer_chk
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        timer_out_pin,
    input wire logic        irq
);
    // All checks share the single clock and its reset
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Write answer follows both handshakes with the stated latency
    property p_wr_resp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");
    property p_b_drop;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_drop: assert property (p_b_drop) else $error("write response held");
    // No new write taken while a response is pending
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken early");
    property p_rd_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read data late");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken early");
    // No register is wider than eight bits, so upper read bits stay zero
    property p_r_upper;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_r_upper: assert property (p_r_upper) else $error("upper read bits set");
    property p_slv_data;
        s_axi_rvalid && s_axi_rresp == tec_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h00000000;
    endproperty
    a_slv_data: assert property (p_slv_data) else $error("error read not zero");
    // Leaving reset, no answer, no interrupt, pin low
    property p_rst;
        $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !timer_out_pin;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == tec_pkg::RESP_SLVERR);
    c_irq: cover property ($rose(irq));
    c_pin: cover property ($rose(timer_out_pin));
endmodule // tec_timer_chk

bind tec_timer tec_timer_chk i_chk
(
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .timer_out_pin, .irq
);

//--- tec_ev_src.sv
// Purpose: External event source driving the event input pin
// Assumes: The bench calls its tasks from the main sequence
// Notes:   Pin idles low, like an input with a pull-down
`timescale 1ns/1ns
module tec_ev_src
(
    input  wire logic aclk,
    output logic      event_in_pin
);
    // Whole pulses, wide enough for the two-flop synchroniser
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge aclk) event_in_pin <= 1'b1;
            repeat (4) @(posedge aclk);
            event_in_pin <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask
    // A slow source just holds a level
    task automatic level(input logic v);
        @(posedge aclk) event_in_pin <= v;
    endtask
    initial event_in_pin = 1'b0;
endmodule // tec_ev_src

//--- test_eight_bit_timer_event_counter.sv
// Purpose: Self-checking bench for the timer channel over AXI4-Lite
// Assumes: 250 MHz clock; reset held for ten cycles
// Notes:   Match delays are judged in a small window around the tick count
`timescale 1ns/1ns
module test_eight_bit_timer_event_counter;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, event_in_pin, timer_out_pin, irq;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  mw [7] = '{8'h08, 8'h09, 8'h01, 8'h05, 8'h0d, 8'h09, 8'h00};
    logic [6:0]  mp = 7'b0100110;
    int          dv [8] = '{0, 0, 1, 2, 4, 64, 256, 8192};
    int          err_count, comparisons, cyc, hi;

    tec_timer i_dut
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_in_pin, .timer_out_pin, .irq
    );
    tec_ev_src i_src (.aclk, .event_in_pin);

    // 4 ns clock
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic final_report;
        $display("Checks %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // A bound that runs out ends the run as a mismatch
    task automatic tmo(input int n);
        if (n >= 40000)
        begin
            err_count++;
            $display("Error wait expected answer seen none");
            final_report();
        end
    endtask

    // Address and data offered together, each released once taken
    task automatic wr(input logic [17:0] a, input logic [7:0] d,
                      input logic [1:0] er = tec_pkg::RESP_OKAY);
        logic aw_ok, w_ok;
        int   n;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok) && n < 40000)
        begin
            @(posedge aclk);
            n++;
            aw_ok |= s_axi_awready;
            w_ok |= s_axi_wready;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        while (!s_axi_bvalid && n < 40000)
        begin
            @(posedge aclk);
            n++;
        end
        tmo(n);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [17:0] a, input logic [31:0] e,
                      input logic [1:0] er = tec_pkg::RESP_OKAY);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 40000);
        tmo(n);
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    task automatic wirq(output int c);
        c = 0;
        while (irq !== 1'b1 && c < 40000)
        begin
            @(posedge aclk);
            c++;
        end
        tmo(c);
    endtask

    // Stop the timer and clear both status bits before a new setup
    task automatic idle;
        wr(tec_pkg::ADDR_MODE_CTL, 8'h00);
        wr(tec_pkg::ADDR_IRQ_STATUS, 8'h03);
    endtask

    initial
    begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_bready, s_axi_rready} = 2'h3;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 68'h0;
        s_axi_wstrb = 4'hf;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(tec_pkg::ADDR_CLK_SEL, 32'h0);
        rd(tec_pkg::ADDR_COMPARE, 32'h0);
        rd(tec_pkg::ADDR_COUNT, 32'h0);
        wr(tec_pkg::ADDR_COMPARE, 8'hff);
        rd(tec_pkg::ADDR_COMPARE, 32'hff);
        wr(tec_pkg::ADDR_CLK_SEL, 8'hff);
        rd(tec_pkg::ADDR_CLK_SEL, 32'h07);
        wr(tec_pkg::ADDR_COUNT, 8'h55);
        rd(tec_pkg::ADDR_COUNT, 32'h0);
        wr(18'h3fc00, 8'h01, tec_pkg::RESP_SLVERR);
        rd(18'h3fc00, 32'h0, tec_pkg::RESP_SLVERR);
        // Flip-flop writes reach the pin only while enabled; 11 is ignored
        for (int i = 0; i < 7; i++)
        begin
            wr(tec_pkg::ADDR_MODE_CTL, mw[i]);
            chk("timer_out_pin", {31'h0, mp[i]}, {31'h0, timer_out_pin});
        end
        wr(tec_pkg::ADDR_MODE_CTL, 8'h4e);
        rd(tec_pkg::ADDR_MODE_CTL, 32'h42);
        // Each tap: first match after compare+1 count periods; restart at zero checked for the 64, 256 and 8192 taps only
        wr(tec_pkg::ADDR_IRQ_MASK, 8'h01);
        wr(tec_pkg::ADDR_COMPARE, 8'h03);
        for (int s = 2; s < 8; s++)
        begin
            idle();
            chk("irq_clear", 32'h0, {31'h0, irq});
            wr(tec_pkg::ADDR_CLK_SEL, 8'(s));
            wr(tec_pkg::ADDR_MODE_CTL, 8'h80);
            wirq(cyc);
            chk("match_delay", 32'h1, {31'h0, cyc + 4 >= 4 * dv[s] && cyc <= 4 * dv[s] + 4});
            if (s > 4)
                rd(tec_pkg::ADDR_COUNT, 32'h0);
        end
        // Event pin: only edges of the chosen polarity count
        wr(tec_pkg::ADDR_COMPARE, 8'h02);
        for (int s = 0; s < 2; s++)
        begin
            idle();
            wr(tec_pkg::ADDR_CLK_SEL, 8'(s));
            wr(tec_pkg::ADDR_MODE_CTL, 8'h83);
            i_src.pulses(2);
            i_src.level(1'b1);
            repeat (8) @(posedge aclk);
            chk("irq_rise", {31'h0, s[0]}, {31'h0, irq});
            i_src.level(1'b0);
            repeat (8) @(posedge aclk);
            chk("irq_fall", 32'h1, {31'h0, irq});
            chk("pin_toggle", {31'h0, s[0]}, {31'h0, timer_out_pin});
        end
        // PWM: pin active from wrap to match, and a match never interrupts
        idle();
        wr(tec_pkg::ADDR_CLK_SEL, 8'h02);
        wr(tec_pkg::ADDR_COMPARE, 8'h80);
        wr(tec_pkg::ADDR_MODE_CTL, 8'hc1);
        hi = 0;
        repeat (4) @(posedge aclk);
        repeat (512)
        begin
            @(posedge aclk);
            hi += int'(timer_out_pin === 1'b1);
        end
        chk("pwm_high", 32'h1, {31'h0, hi >= 253 && hi <= 259});
        chk("irq_pwm", 32'h0, {31'h0, irq});
        wr(tec_pkg::ADDR_MODE_CTL, 8'h01);
        rd(tec_pkg::ADDR_COUNT, 32'h0);
        rd(tec_pkg::ADDR_IRQ_STATUS, 32'h2);
        wr(tec_pkg::ADDR_IRQ_MASK, 8'h03);
        chk("irq_unmask", 32'h1, {31'h0, irq});
        wr(tec_pkg::ADDR_IRQ_STATUS, 8'h02);
        chk("irq_w1c", 32'h0, {31'h0, irq});
        final_report();
    end
endmodule // test_eight_bit_timer_event_counter
